//--- core/afoa_pkg.sv
`default_nettype none
package afoa_pkg;
	// ********************************************************************
	// widths
	// ********************************************************************
	localparam int ADDR_W        = 8;
	localparam int DATA_W        = 32;
	localparam int BYTE_W        = 8;
	localparam int PTR_W         = 12;
	localparam int BANK_W        = 4;
	localparam int FLAG_W        = 5;
	localparam int PC_W          = 22;
	localparam int PC_LIT_W      = 20;
	localparam int PC_SERIAL_BIT = 21;
	// ********************************************************************
	// register byte offsets
	// ********************************************************************
	localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_WREG    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BANK    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PTR0    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PTR1    = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PTR2    = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_PC      = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_MEMADDR = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_MEMDATA = 8'h2c;
	localparam logic [ADDR_W-1:0] OFS_MOVDST  = 8'h30;
	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int FLG_C = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N = 4;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_D = 4;
	localparam int CMD_A = 5;
	localparam int CMD_IND = 6;
	localparam int CMD_PSEL_LSB = 8;
	localparam int CMD_PMODE_LSB = 10;
	localparam int CMD_F_LSB = 16;
	localparam int CFG_EXT = 0;
	localparam int CFG_SERIAL = 1;
	localparam int RES_ADDR_LSB = 16;
	localparam int RES_TO_W = 30;
	localparam int RES_BUSY = 31;
	// ********************************************************************
	// constants
	// ********************************************************************
	localparam logic [PTR_W-1:0]  FLAGS_ADDR   = 12'hfd8;
	localparam logic [7:0]        ACCESS_SPLIT = 8'h60;
	localparam logic [7:0]        IDX_LIMIT    = 8'h5f;
	localparam logic [BANK_W-1:0] ACCESS_LO    = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HI    = 4'hf;
	localparam logic [FLAG_W-1:0] MASK_ALL     = 5'h1f;
	localparam logic [FLAG_W-1:0] MASK_ZN      = 5'h14;
	localparam logic [FLAG_W-1:0] MASK_Z       = 5'h04;
	localparam logic [FLAG_W-1:0] MASK_ROT     = 5'h17;
	localparam logic [FLAG_W-1:0] MASK_NONE    = 5'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RST    = 5'h00;
	localparam logic [1:0]        RESP_OKAY    = 2'h0;
	localparam logic [1:0]        RESP_SLVERR  = 2'h2;
	// ********************************************************************
	// types
	// ********************************************************************
	typedef enum logic [3:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_MOVF,
		OP_RRC, OP_RLC, OP_SWAP, OP_ADDLW, OP_SUBLW, OP_MOVE_FULL_ADDRESS_OP
	} afoa_op_t;
	typedef enum logic [2:0] {
		PM_PLAIN, PM_AFTER_INCREMENT_OPERAND, PM_POSTDEC, PM_PREINC, PM_PLUSW
	} afoa_pmode_t;
endpackage
`default_nettype wire

//--- core/afoa_core.sv
// Summary of operation
// - flag register as destination keeps ALU flags, ignores written five bits, except swap and full-address move, which write them
// - clear-file on flag register sets only zero flag
// - flag bits 7 to 5 always read zero
// - negative flag in bit 4 copies result bit 7
// - signed wrap flag in bit 3 marks signed overflow
// - zero flag in bit 2 set when result is zero
// - nibble carry in bit 1 is carry out of bit 3 for add/sub
// - carry in bit 0 is carry out of bit 7 for add/sub
// - subtract adds two's complement, carries act as active-low borrows
// - rotates load nibble carry from bit 4/3 and carry from rotated bit
// - command bits 23 to 16 are the direct file address
// - access select one combines bank register with file address
// - access select zero uses access bank, ignores bank register
// - full-address move ignores bank register
// - destination bit one writes file, zero writes working register
// - jump target literal of 20 bits loads program counter
// - indexed literal offset only with extended set enabled
// - pointer pairs give indirect address with auto inc, dec or offset
// - program counter bit 21 reachable only in serial programming mode
// - pointer pairs hold 12-bit addresses
// - after-increment uses pointer then adds one with carry through
// - pointer updates leave arithmetic flags alone
`timescale 1ns/1ps
`default_nettype none
module afoa_core #(
	parameter int MEM_DEPTH = 4096
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic [afoa_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [afoa_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	output logic [1:0]                        s_axi_bresp,
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [afoa_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	output logic [afoa_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	// ********************************************************************
	// helpers
	// ********************************************************************
	function automatic logic hit(input logic [afoa_pkg::ADDR_W-1:0] a,
			input logic [afoa_pkg::ADDR_W-1:0] ofs);
		return a[afoa_pkg::ADDR_W-1:2] == ofs[afoa_pkg::ADDR_W-1:2];
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// bit 9 nibble carry, bit 8 carry, bits 7..0 sum
	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
			input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		return {lo[4], full};
	endfunction

	// ********************************************************************
	// state
	// ********************************************************************
	logic [afoa_pkg::FLAG_W-1:0]  flags_r;
	logic [7:0]                   wreg_r;
	logic [afoa_pkg::BANK_W-1:0]  bank_r;
	logic [afoa_pkg::PTR_W-1:0]   ptr_r [0:2];
	logic [31:0]                  cmd_r;
	logic                         go_r;
	logic                         ext_en_r;
	logic                         serial_r;
	logic [afoa_pkg::PC_W-1:0]    pc_r;
	logic [afoa_pkg::PTR_W-1:0]   memaddr_r;
	logic [afoa_pkg::PTR_W-1:0]   movdst_r;
	logic [afoa_pkg::PTR_W-1:0]   last_addr_r;
	logic [7:0]                   last_res_r;
	logic                         last_to_w_r;
	logic [7:0]                   mem_r [0:MEM_DEPTH-1];

	// ********************************************************************
	// axi4-lite write channel
	// ********************************************************************
	// both address and data are taken on one edge; exec cycles hold off a
	// new write so bus and instruction never update a register together
	logic        wr_fire;
	logic [31:0] wmerged;
	logic        wr_mapped;
	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign wmerged = merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);

	always_comb begin
		if (hit(s_axi_awaddr, afoa_pkg::OFS_FLAGS) || hit(s_axi_awaddr, afoa_pkg::OFS_WREG)
				|| hit(s_axi_awaddr, afoa_pkg::OFS_BANK)) begin
			wr_mapped = 1'b1;
		end else if (hit(s_axi_awaddr, afoa_pkg::OFS_PTR0) || hit(s_axi_awaddr, afoa_pkg::OFS_PTR1)
				|| hit(s_axi_awaddr, afoa_pkg::OFS_PTR2)) begin
			wr_mapped = 1'b1;
		end else if (hit(s_axi_awaddr, afoa_pkg::OFS_CMD) || hit(s_axi_awaddr, afoa_pkg::OFS_CONFIG)
				|| hit(s_axi_awaddr, afoa_pkg::OFS_PC)) begin
			wr_mapped = 1'b1;
		end else if (hit(s_axi_awaddr, afoa_pkg::OFS_MEMADDR)
				|| hit(s_axi_awaddr, afoa_pkg::OFS_MEMDATA)
				|| hit(s_axi_awaddr, afoa_pkg::OFS_MOVDST)) begin
			wr_mapped = 1'b1;
		end else begin
			wr_mapped = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_awready) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !go_r) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= afoa_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? afoa_pkg::RESP_OKAY : afoa_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ********************************************************************
	// operand addressing
	// ********************************************************************
	afoa_pkg::afoa_op_t    op;
	afoa_pkg::afoa_pmode_t pmode;
	logic [7:0]                 fld;
	logic [1:0]                 psel;
	logic [1:0]                 pidx;
	logic [afoa_pkg::PTR_W-1:0] pval;
	logic [afoa_pkg::PTR_W-1:0] pnew;
	logic                       pupd;
	logic [afoa_pkg::PTR_W-1:0] opnd_addr;
	logic [7:0]                 src;
	assign op = afoa_pkg::afoa_op_t'(cmd_r[afoa_pkg::CMD_OP_LSB +: 4]);
	assign pmode = afoa_pkg::afoa_pmode_t'(cmd_r[afoa_pkg::CMD_PMODE_LSB +: 3]);
	assign fld = cmd_r[afoa_pkg::CMD_F_LSB +: 8];
	assign psel = cmd_r[afoa_pkg::CMD_PSEL_LSB +: 2];
	assign pidx = (psel == 2'h3) ? 2'h2 : psel;
	assign pval = ptr_r[pidx];

	always_comb begin
		pnew = pval;
		pupd = 1'b0;
		if (cmd_r[afoa_pkg::CMD_IND]) begin
			// no bank or access bit in the address here
			case (pmode)
				afoa_pkg::PM_AFTER_INCREMENT_OPERAND: begin
					opnd_addr = pval;
					pnew = pval + 12'h001;
					pupd = 1'b1;
				end
				afoa_pkg::PM_POSTDEC: begin
					opnd_addr = pval;
					pnew = pval - 12'h001;
					pupd = 1'b1;
				end
				afoa_pkg::PM_PREINC: begin
					pnew = pval + 12'h001;
					opnd_addr = pnew;
					pupd = 1'b1;
				end
				afoa_pkg::PM_PLUSW: begin
					opnd_addr = pval + {{4{wreg_r[7]}}, wreg_r};
				end
				default: begin
					opnd_addr = pval;
				end
			endcase
		end else if (op == afoa_pkg::OP_MOVE_FULL_ADDRESS_OP) begin
			opnd_addr = memaddr_r;
		end else if (cmd_r[afoa_pkg::CMD_A]) begin
			opnd_addr = {bank_r, fld};
		end else if (ext_en_r && fld <= afoa_pkg::IDX_LIMIT) begin
			opnd_addr = ptr_r[2] + {4'h0, fld};
		end else if (fld < afoa_pkg::ACCESS_SPLIT) begin
			opnd_addr = {afoa_pkg::ACCESS_LO, fld};
		end else begin
			opnd_addr = {afoa_pkg::ACCESS_HI, fld};
		end
	end

	assign src = (opnd_addr == afoa_pkg::FLAGS_ADDR) ? {3'h0, flags_r} : mem_r[opnd_addr];

	// ********************************************************************
	// alu and flag logic
	// ********************************************************************
	logic [7:0]                 add_a;
	logic [7:0]                 add_b;
	logic                       add_c;
	logic [9:0]                 sum;
	logic [7:0]                 res;
	logic [afoa_pkg::FLAG_W-1:0] calc;
	logic [afoa_pkg::FLAG_W-1:0] mask;
	logic                       to_w;
	logic                       to_file;
	logic [afoa_pkg::PTR_W-1:0] tgt;
	logic                       rot_c;
	logic                       rot_dc;
	logic                       arith;
	logic                       lit_op;

	assign lit_op = (op == afoa_pkg::OP_ADDLW) || (op == afoa_pkg::OP_SUBLW);
	assign arith = lit_op || (op == afoa_pkg::OP_ADD) || (op == afoa_pkg::OP_SUB);
	assign add_a = lit_op ? fld : src;
	// subtraction is addition of the inverted working register plus one
	assign add_b = (op == afoa_pkg::OP_SUB || op == afoa_pkg::OP_SUBLW) ? ~wreg_r : wreg_r;
	assign add_c = (op == afoa_pkg::OP_SUB || op == afoa_pkg::OP_SUBLW);
	assign sum = add8(add_a, add_b, add_c);

	always_comb begin
		rot_c = 1'b0;
		rot_dc = 1'b0;
		case (op)
			afoa_pkg::OP_ADD, afoa_pkg::OP_SUB, afoa_pkg::OP_ADDLW, afoa_pkg::OP_SUBLW: begin
				res = sum[7:0];
				mask = afoa_pkg::MASK_ALL;
			end
			afoa_pkg::OP_AND: begin
				res = src & wreg_r;
				mask = afoa_pkg::MASK_ZN;
			end
			afoa_pkg::OP_IOR: begin
				res = src | wreg_r;
				mask = afoa_pkg::MASK_ZN;
			end
			afoa_pkg::OP_XOR: begin
				res = src ^ wreg_r;
				mask = afoa_pkg::MASK_ZN;
			end
			afoa_pkg::OP_CLR: begin
				res = 8'h00;
				mask = afoa_pkg::MASK_Z;
			end
			afoa_pkg::OP_MOVF: begin
				res = src;
				mask = afoa_pkg::MASK_ZN;
			end
			afoa_pkg::OP_RRC: begin
				res = {flags_r[afoa_pkg::FLG_C], src[7:1]};
				rot_c = src[0];
				rot_dc = src[4];
				mask = afoa_pkg::MASK_ROT;
			end
			afoa_pkg::OP_RLC: begin
				res = {src[6:0], flags_r[afoa_pkg::FLG_C]};
				rot_c = src[7];
				rot_dc = src[3];
				mask = afoa_pkg::MASK_ROT;
			end
			afoa_pkg::OP_SWAP: begin
				res = {src[3:0], src[7:4]};
				mask = afoa_pkg::MASK_NONE;
			end
			afoa_pkg::OP_MOVE_FULL_ADDRESS_OP: begin
				res = src;
				mask = afoa_pkg::MASK_NONE;
			end
			default: begin
				res = src;
				mask = afoa_pkg::MASK_NONE;
			end
		endcase
	end

	always_comb begin
		calc = afoa_pkg::FLAGS_RST;
		calc[afoa_pkg::FLG_N] = res[7];
		calc[afoa_pkg::FLG_Z] = (res == 8'h00);
		calc[afoa_pkg::FLG_OV] = (add_a[7] == add_b[7]) && (sum[7] != add_a[7]);
		calc[afoa_pkg::FLG_DC] = arith ? sum[9] : rot_dc;
		calc[afoa_pkg::FLG_C] = arith ? sum[8] : rot_c;
	end

	// literal ops always land in w, clear and full move always in a file
	always_comb begin
		if (op == afoa_pkg::OP_NOP || op > afoa_pkg::OP_MOVE_FULL_ADDRESS_OP) begin
			to_w = 1'b0;
			to_file = 1'b0;
		end else if (lit_op) begin
			to_w = 1'b1;
			to_file = 1'b0;
		end else if (op == afoa_pkg::OP_CLR || op == afoa_pkg::OP_MOVE_FULL_ADDRESS_OP) begin
			to_w = 1'b0;
			to_file = 1'b1;
		end else begin
			to_w = !cmd_r[afoa_pkg::CMD_D];
			to_file = cmd_r[afoa_pkg::CMD_D];
		end
	end
	assign tgt = (op == afoa_pkg::OP_MOVE_FULL_ADDRESS_OP) ? movdst_r : opnd_addr;

	// strobe-merged bus words for the flag and pointer registers
	logic [31:0] fl_wr;
	logic [31:0] p0_wr;
	logic [31:0] p1_wr;
	logic [31:0] p2_wr;
	assign fl_wr = merge({27'h0, flags_r}, s_axi_wdata, s_axi_wstrb);
	assign p0_wr = merge({20'h0, ptr_r[0]}, s_axi_wdata, s_axi_wstrb);
	assign p1_wr = merge({20'h0, ptr_r[1]}, s_axi_wdata, s_axi_wstrb);
	assign p2_wr = merge({20'h0, ptr_r[2]}, s_axi_wdata, s_axi_wstrb);

	// ********************************************************************
	// architectural registers
	// ********************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_r <= 1'b0;
			cmd_r <= 32'h0000_0000;
		end else begin
			go_r <= wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_CMD);
			if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_CMD)) begin
				cmd_r <= merge(cmd_r, s_axi_wdata, s_axi_wstrb);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_r <= afoa_pkg::FLAGS_RST;
		end else if (go_r) begin
			if (to_file && tgt == afoa_pkg::FLAGS_ADDR && mask == afoa_pkg::MASK_NONE) begin
				flags_r <= res[afoa_pkg::FLAG_W-1:0];
			end else begin
				// written value dropped: only the op's own flags move
				flags_r <= (flags_r & ~mask) | (calc & mask);
			end
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_FLAGS)) begin
			flags_r <= fl_wr[afoa_pkg::FLAG_W-1:0];
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_MEMDATA)
				&& memaddr_r == afoa_pkg::FLAGS_ADDR && s_axi_wstrb[0]) begin
			flags_r <= s_axi_wdata[afoa_pkg::FLAG_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wreg_r <= 8'h00;
		end else if (go_r && to_w) begin
			wreg_r <= res;
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_WREG) && s_axi_wstrb[0]) begin
			wreg_r <= s_axi_wdata[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (go_r && to_file && tgt != afoa_pkg::FLAGS_ADDR) begin
			mem_r[tgt] <= res;
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_MEMDATA) && s_axi_wstrb[0]
				&& memaddr_r != afoa_pkg::FLAGS_ADDR) begin
			mem_r[memaddr_r] <= s_axi_wdata[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 3; i++) begin
				ptr_r[i] <= 12'h000;
			end
		end else if (go_r && cmd_r[afoa_pkg::CMD_IND] && pupd) begin
			ptr_r[pidx] <= pnew;
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_PTR0)) begin
			ptr_r[0] <= p0_wr[afoa_pkg::PTR_W-1:0];
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_PTR1)) begin
			ptr_r[1] <= p1_wr[afoa_pkg::PTR_W-1:0];
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_PTR2)) begin
			ptr_r[2] <= p2_wr[afoa_pkg::PTR_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bank_r <= 4'h0;
			ext_en_r <= 1'b0;
			serial_r <= 1'b0;
			memaddr_r <= 12'h000;
			movdst_r <= 12'h000;
		end else if (wr_fire) begin
			if (hit(s_axi_awaddr, afoa_pkg::OFS_BANK) && s_axi_wstrb[0]) begin
				bank_r <= s_axi_wdata[afoa_pkg::BANK_W-1:0];
			end else if (hit(s_axi_awaddr, afoa_pkg::OFS_CONFIG) && s_axi_wstrb[0]) begin
				ext_en_r <= s_axi_wdata[afoa_pkg::CFG_EXT];
				serial_r <= s_axi_wdata[afoa_pkg::CFG_SERIAL];
			end else if (hit(s_axi_awaddr, afoa_pkg::OFS_MEMADDR)) begin
				memaddr_r <= wmerged[afoa_pkg::PTR_W-1:0];
			end else if (hit(s_axi_awaddr, afoa_pkg::OFS_MOVDST)) begin
				movdst_r <= wmerged[afoa_pkg::PTR_W-1:0];
			end
		end
	end

	// a jump clears bit 20; bit 21 moves only while serial mode is on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_r <= 22'h00_0000;
		end else if (wr_fire && hit(s_axi_awaddr, afoa_pkg::OFS_PC) && s_axi_wstrb == 4'hf) begin
			pc_r[afoa_pkg::PC_LIT_W-1:0] <= s_axi_wdata[afoa_pkg::PC_LIT_W-1:0];
			pc_r[afoa_pkg::PC_LIT_W] <= 1'b0;
			if (serial_r) begin
				pc_r[afoa_pkg::PC_SERIAL_BIT] <= s_axi_wdata[afoa_pkg::PC_SERIAL_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_addr_r <= 12'h000;
			last_res_r <= 8'h00;
			last_to_w_r <= 1'b0;
		end else if (go_r) begin
			last_addr_r <= tgt;
			last_res_r <= res;
			last_to_w_r <= to_w;
		end
	end

	// ********************************************************************
	// axi4-lite read channel
	// ********************************************************************
	logic [31:0] rd_nxt;
	logic        rd_ok_nxt;
	logic [7:0]  memrd;
	assign memrd = (memaddr_r == afoa_pkg::FLAGS_ADDR) ? {3'h0, flags_r} : mem_r[memaddr_r];

	always_comb begin
		rd_ok_nxt = 1'b1;
		if (hit(s_axi_araddr, afoa_pkg::OFS_FLAGS)) begin
			rd_nxt = {27'h0, flags_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_WREG)) begin
			rd_nxt = {24'h0, wreg_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_BANK)) begin
			rd_nxt = {28'h0, bank_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_PTR0)) begin
			rd_nxt = {20'h0, ptr_r[0]};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_PTR1)) begin
			rd_nxt = {20'h0, ptr_r[1]};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_PTR2)) begin
			rd_nxt = {20'h0, ptr_r[2]};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_CMD)) begin
			rd_nxt = cmd_r;
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_RESULT)) begin
			rd_nxt = {go_r, last_to_w_r, 2'h0, last_addr_r, 8'h00, last_res_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_CONFIG)) begin
			rd_nxt = {30'h0, serial_r, ext_en_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_PC)) begin
			rd_nxt = {10'h0, pc_r[afoa_pkg::PC_SERIAL_BIT] & serial_r,
				pc_r[afoa_pkg::PC_LIT_W:0]};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_MEMADDR)) begin
			rd_nxt = {20'h0, memaddr_r};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_MEMDATA)) begin
			rd_nxt = {24'h0, memrd};
		end else if (hit(s_axi_araddr, afoa_pkg::OFS_MOVDST)) begin
			rd_nxt = {20'h0, movdst_r};
		end else begin
			rd_nxt = 32'h0000_0000;
			rd_ok_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_arready) begin
			s_axi_arready <= 1'b0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= afoa_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_nxt;
			s_axi_rresp <= rd_ok_nxt ? afoa_pkg::RESP_OKAY : afoa_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- sim/afoa_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module afoa_core_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic [31:0] s_axi_rdata
);
	logic flag_rd_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// remembers a flag register read until its data shows
	always_ff @(posedge aclk) begin
		if (!aresetn) flag_rd_r <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready) flag_rd_r <= (s_axi_araddr[7:2] == 6'h00);
	end
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_wvalid && s_axi_awready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_ready_pair: assert property (s_axi_awready |-> s_axi_wready) else $error("readies split");
	a_bvalid_next: assert property (s_wr_taken |=> s_axi_bvalid) else $error("no write answer");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_write_stall: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken early");
	a_rvalid_next: assert property (s_rd_taken |=> s_axi_rvalid) else $error("no read answer");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready) else $error("arready held");
	a_flag_top_zero: assert property (s_axi_rvalid && flag_rd_r |->
		s_axi_rdata[31:5] == 27'h0) else $error("flag top bits set");
endmodule
bind afoa_core afoa_core_chk chk (.*);
`default_nettype wire

//--- sim/alu_flags_and_operand_addressing_bench.sv
`timescale 1ns/1ps
`default_nettype none
module alu_flags_and_operand_addressing_bench;
	typedef struct packed {logic [3:0] op; logic [7:0] fv, wv, res; logic [4:0] fl;} afoa_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_v;
	logic [1:0] bresp, rresp, resp_v;
	int fails = 0, n_checks = 0, cyc = 0;
	afoa_row_t rows [7] = '{'{4'h1, 8'h7f, 8'h01, 8'h80, 5'h1a}, '{4'h2, 8'h05, 8'h05, 8'h00, 5'h07},
		'{4'h2, 8'h03, 8'h05, 8'hfe, 5'h10}, '{4'h3, 8'hf0, 8'h0f, 8'h00, 5'h04},
		'{4'h5, 8'h80, 8'h00, 8'h80, 5'h10}, '{4'h9, 8'h88, 8'h00, 8'h10, 5'h03},
		'{4'h8, 8'h11, 8'h00, 8'h08, 5'h03}};
	afoa_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	initial forever #2.5 aclk = ~aclk;
	task automatic conclude();
		if (fails == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// ready is raised late on purpose so the answer is seen waiting
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		do @(posedge aclk); while (!(awready && wready));
		awvalid <= 1'b0; wvalid <= 1'b0;
		do @(posedge aclk); while (!bvalid);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0; resp_v = bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0; rd_v = rdata; resp_v = rresp;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_v, e);
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(afoa_pkg::OFS_FLAGS, 32'h0);
		foreach (rows[i]) begin
			wr(afoa_pkg::OFS_FLAGS, 32'h0); wr(afoa_pkg::OFS_MEMADDR, 32'h010);
			wr(afoa_pkg::OFS_MEMDATA, {24'h0, rows[i].fv}); wr(afoa_pkg::OFS_WREG, {24'h0, rows[i].wv});
			wr(afoa_pkg::OFS_CMD, {8'h0, 8'h10, 12'h0, rows[i].op});
			rd(afoa_pkg::OFS_RESULT);
			chk(rd_v & 32'h4fff00ff, {8'h40, 8'h10, 8'h0, rows[i].res});
			rc(afoa_pkg::OFS_FLAGS, {27'h0, rows[i].fl});
		end
		wr(afoa_pkg::OFS_FLAGS, 32'h01); wr(afoa_pkg::OFS_WREG, 32'hff); wr(afoa_pkg::OFS_BANK, 32'hf);
		wr(afoa_pkg::OFS_CMD, 32'h00d80031);
		rc(afoa_pkg::OFS_FLAGS, 32'h07);
		wr(afoa_pkg::OFS_FLAGS, 32'h1a); wr(afoa_pkg::OFS_CMD, 32'h00d80036);
		rc(afoa_pkg::OFS_FLAGS, 32'h1e);
		rd(afoa_pkg::OFS_RESULT);
		chk(rd_v & 32'h0fff0000, 32'h0fd80000);
		wr(afoa_pkg::OFS_FLAGS, 32'hff);
		rc(afoa_pkg::OFS_FLAGS, 32'h1f);
		wr(afoa_pkg::OFS_FLAGS, 32'h0b); wr(afoa_pkg::OFS_PTR0, 32'h0ff); wr(afoa_pkg::OFS_CMD, 32'h44a);
		rc(afoa_pkg::OFS_PTR0, 32'h100);
		rc(afoa_pkg::OFS_FLAGS, 32'h0b);
		rd(afoa_pkg::OFS_RESULT);
		chk(rd_v & 32'h0fff0000, 32'h00ff0000);
		wr(afoa_pkg::OFS_CONFIG, 32'h1); wr(afoa_pkg::OFS_PTR2, 32'h200);
		wr(afoa_pkg::OFS_CMD, 32'h0005000a);
		rd(afoa_pkg::OFS_RESULT);
		chk(rd_v & 32'h0fff0000, 32'h02050000);
		// full-address move with a=1 and a bank set: bank must not be used
		wr(afoa_pkg::OFS_MEMADDR, 32'h123);
		wr(afoa_pkg::OFS_MEMDATA, 32'h5a);
		wr(afoa_pkg::OFS_MOVDST, 32'h234);
		wr(afoa_pkg::OFS_CMD, 32'h0099003d);
		wr(afoa_pkg::OFS_MEMADDR, 32'h234);
		rc(afoa_pkg::OFS_MEMDATA, 32'h5a);
		wr(afoa_pkg::OFS_BANK, 32'h2);
		wr(afoa_pkg::OFS_WREG, 32'h1);
		wr(afoa_pkg::OFS_CMD, 32'h00340031);
		rc(afoa_pkg::OFS_MEMDATA, 32'h5b);
		wr(afoa_pkg::OFS_CONFIG, 32'h0); wr(afoa_pkg::OFS_PC, 32'h3fffff);
		rc(afoa_pkg::OFS_PC, 32'h0fffff);
		wr(afoa_pkg::OFS_CONFIG, 32'h2); wr(afoa_pkg::OFS_PC, 32'h3fffff);
		rc(afoa_pkg::OFS_PC, 32'h2fffff);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(afoa_pkg::OFS_PC, 32'h0);
		rc(afoa_pkg::OFS_PTR0, 32'h0);
		wr(8'h3c, 32'h1);
		chk({30'h0, resp_v}, 32'h2);
		rd(8'h3c);
		chk({resp_v, rd_v[29:0]}, 32'h80000000);
		conclude();
	end
endmodule
`default_nettype wire
